/* File: core/qsx_pkg.sv */
// Package for the quad serial XIP / descriptor register slice.
// Assumes one clock domain (mclk, 25 MHz) and synchronous reset.
package qsx_pkg;
  // Register indices (byte address = 4 * index)
  localparam logic [3:0] XIP_CTRL2_IDX   = 4'h0;
  localparam logic [3:0] BD_POLL_IDX     = 4'h1;
  localparam logic [3:0] TX_STAT_IDX     = 4'h2;
  localparam logic [3:0] XIP_CMD_IDX     = 4'h3;
  localparam logic [3:0] BD_CMD_IDX      = 4'h4;
  localparam logic [3:0] BD_STAT_IDX     = 4'h5;
  // Field positions
  localparam int TGT_SEL_LSB = 10;
  localparam int MCOUNT_LSB  = 8;
  localparam int TX_ST_LSB   = 25;
  localparam int TXSPACE_LSB = 16;
  // Reset values
  localparam logic [15:0] POLL_RST  = 16'h0000;
  localparam logic [7:0]  MCODE_RST = 8'h00;
  localparam logic [1:0]  DSEL_RST  = 2'h0;
  localparam logic [1:0]  MCNT_RST  = 2'h0;
  localparam logic [4:0]  FIFO_DEPTH = 5'h10;
  // Phase lengths used until software writes the command register
  localparam logic [2:0]  ADDR_CYC_RST  = 3'h6;
  localparam logic [2:0]  DUMMY_CYC_RST = 3'h4;
  localparam logic [3:0]  DATA_CYC_RST  = 4'h8;
  // Target select codes
  localparam logic [1:0]  DSEL_DEV0 = 2'h0;
  localparam logic [1:0]  DSEL_DEV1 = 2'h1;
  // XIP sequence states
  typedef enum logic [2:0] {
    XS_IDLE  = 3'b000,
    XS_ADDR  = 3'b001,
    XS_MODE  = 3'b010,
    XS_DUMMY = 3'b011,
    XS_DATA  = 3'b100
  } qsx_xip_st_t;
  // Transmit DMA states
  typedef enum logic [3:0] {
    TS_IDLE  = 4'h0,
    TS_FETCH = 4'h1,
    TS_POLL  = 4'h2,
    TS_XFER  = 4'h3
  } qsx_tx_st_t;
endpackage

/* File: core/qsx_cfg_if.sv */
// Interface carrying XIP settings from the registers to the sequencer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
interface qsx_cfg_if;
  logic [1:0] flash_target_select;
  logic [1:0] mode_cycle_count;
  logic [7:0] mode_code_value;
  modport regs (output flash_target_select, output mode_cycle_count,
                output mode_code_value);
  modport seq  (input flash_target_select, input mode_cycle_count,
                input mode_code_value);
endinterface

/* File: core/qsx_xip_seq.sv */
// XIP phase sequencer: address, mode cycles, dummy, data.
// Assumes a one-cycle start pulse from the transfer logic.
`timescale 1ns/1ns
module qsx_xip_seq (
  input  wire logic       mclk,
  input  wire logic       rst,
  qsx_cfg_if.seq          cfg,
  input  wire logic       xip_start,
  input  wire logic [2:0] addr_cycles,
  input  wire logic [2:0] dummy_cycles,
  input  wire logic [3:0] data_cycles,
  output logic [2:0]      phase_q,
  output logic [7:0]      mode_out_q,
  output logic            mode_valid_q,
  output logic            cs_n_q,
  output logic [1:0]      dev_q
);
  qsx_pkg::qsx_xip_st_t st_q;
  logic [3:0] cnt_q;

  // Phase progression; mode cycles sit after address, before dummy
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q <= qsx_pkg::XS_IDLE;
      cnt_q <= 4'h0;
    end
    else
    begin
      case (st_q)
        qsx_pkg::XS_IDLE:
          if (xip_start)
          begin
            st_q <= qsx_pkg::XS_ADDR;
            cnt_q <= {1'b0, addr_cycles};
          end
        qsx_pkg::XS_ADDR:
          if (cnt_q <= 4'h1)
          begin
            if (cfg.mode_cycle_count != 2'h0)
            begin
              st_q <= qsx_pkg::XS_MODE;
              cnt_q <= {2'h0, cfg.mode_cycle_count};
            end
            else
            begin
              st_q <= qsx_pkg::XS_DUMMY;
              cnt_q <= {1'b0, dummy_cycles};
            end
          end
          else
            cnt_q <= cnt_q - 4'h1;
        qsx_pkg::XS_MODE:
          if (cnt_q <= 4'h1)
          begin
            st_q <= qsx_pkg::XS_DUMMY;
            cnt_q <= {1'b0, dummy_cycles};
          end
          else
            cnt_q <= cnt_q - 4'h1;
        qsx_pkg::XS_DUMMY:
          if (cnt_q <= 4'h1)
          begin
            st_q <= qsx_pkg::XS_DATA;
            cnt_q <= data_cycles;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        qsx_pkg::XS_DATA:
          if (cnt_q <= 4'h1)
            st_q <= qsx_pkg::XS_IDLE;
          else
            cnt_q <= cnt_q - 4'h1;
        default:
          st_q <= qsx_pkg::XS_IDLE;
      endcase
    end
  end

  // Registered outputs; mode bits carry the stored code
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      phase_q <= 3'h0;
      mode_out_q <= 8'h00;
      mode_valid_q <= 1'b0;
      cs_n_q <= 1'b1;
      dev_q <= 2'h0;
    end
    else
    begin
      phase_q <= st_q;
      mode_valid_q <= (st_q == qsx_pkg::XS_MODE);
      mode_out_q <= (st_q == qsx_pkg::XS_MODE) ?
                    cfg.mode_code_value : 8'h00;
      cs_n_q <= (st_q == qsx_pkg::XS_IDLE);
      if (st_q == qsx_pkg::XS_IDLE && xip_start)
        dev_q <= cfg.flash_target_select;
    end
  end
endmodule

/* File: core/qsx_bd_tx_fsm.sv */
// Descriptor processor and transmit DMA status tracker.
// Assumes descriptor fetch answers arrive on mclk.
`timescale 1ns/1ns
module qsx_bd_tx_fsm (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        bd_go,
  input  wire logic [15:0] descriptor_poll_wait,
  input  wire logic        fetch_done,
  input  wire logic        fetch_enabled,
  input  wire logic [7:0]  fetch_len,
  input  wire logic        byte_out,
  output logic             fetch_req_q,
  output logic [3:0]       tx_dma_state_q,
  output logic [4:0]       tx_fifo_space_q,
  output logic [7:0]       tx_current_buffer_length_q
);
  qsx_pkg::qsx_tx_st_t st_q;
  logic [15:0] wait_q;
  // Bytes still to send; kept apart so the length field reads back whole
  logic [7:0]  left_q;

  // Fetch, wait on a disabled descriptor, then refetch
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q <= qsx_pkg::TS_IDLE;
      wait_q <= 16'h0000;
      left_q <= 8'h00;
      fetch_req_q <= 1'b0;
      tx_current_buffer_length_q <= 8'h00;
    end
    else
    begin
      fetch_req_q <= 1'b0;
      case (st_q)
        qsx_pkg::TS_IDLE:
          if (bd_go)
          begin
            st_q <= qsx_pkg::TS_FETCH;
            fetch_req_q <= 1'b1;
          end
        qsx_pkg::TS_FETCH:
          if (fetch_done)
          begin
            if (fetch_enabled)
            begin
              st_q <= qsx_pkg::TS_XFER;
              tx_current_buffer_length_q <= fetch_len;
              left_q <= fetch_len;
            end
            else
            begin
              st_q <= qsx_pkg::TS_POLL;
              wait_q <= descriptor_poll_wait;
            end
          end
        qsx_pkg::TS_POLL:
          if (wait_q == 16'h0000)
          begin
            st_q <= qsx_pkg::TS_FETCH;
            fetch_req_q <= 1'b1;
          end
          else
            wait_q <= wait_q - 16'h0001;
        qsx_pkg::TS_XFER:
          if (byte_out && left_q <= 8'h01)
          begin
            left_q <= 8'h00;
            tx_current_buffer_length_q <= 8'h00;
            st_q <= qsx_pkg::TS_FETCH;
            fetch_req_q <= 1'b1;
          end
          else if (byte_out)
            left_q <= left_q - 8'h01; // Length field holds
        default:
          st_q <= qsx_pkg::TS_IDLE;
      endcase
    end
  end

  // State and FIFO space for status reads
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_dma_state_q <= 4'h0;
      tx_fifo_space_q <= qsx_pkg::FIFO_DEPTH;
    end
    else
    begin
      tx_dma_state_q <= st_q;
      if (st_q == qsx_pkg::TS_XFER && byte_out &&
          tx_fifo_space_q != 5'h00)
        tx_fifo_space_q <= tx_fifo_space_q - 5'h01;
      else if (st_q != qsx_pkg::TS_XFER)
        tx_fifo_space_q <= qsx_pkg::FIFO_DEPTH;
    end
  end
endmodule

/* File: core/qsx_regs.sv */
// Register slice: XIP control, descriptor poll and transmit DMA status.
// Contract
// - Target select 00 device0, 01 device1
// - Mode cycle count gives zero to three
// - Stored eight-bit code drives mode bits
// - XIP control bits 31-12 read zero
// - Disabled descriptor waits poll count, refetches
// - Poll bits 31-16 zero; count resets zero
// - Read-only four-bit transmit DMA state
// - Read-only five-bit transmit FIFO space
// - Read-only eight-bit current buffer length
// - Status bits 31-29,24-21,15-8 read zero
// Assumes a plain strobe bus on mclk and sync active-high rst.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module qsx_regs (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        fetch_done,
  input  wire logic        fetch_enabled,
  input  wire logic [7:0]  fetch_len,
  input  wire logic        byte_out,
  output logic [31:0]      reg_rdata_q,
  output logic             fetch_req_q,
  output logic [2:0]       xip_phase_q,
  output logic [7:0]       mode_out_q,
  output logic             mode_valid_q,
  output logic             flash_cs_n_q,
  output logic [1:0]       flash_dev_q
);
  qsx_cfg_if cfg ();
  logic [1:0]  dsel_q;
  logic [1:0]  mcnt_q;
  logic [7:0]  mcode_q;
  logic [15:0] poll_q;
  logic [2:0]  addr_cyc_q;
  logic [2:0]  dummy_cyc_q;
  logic [3:0]  data_cyc_q;
  logic        xip_start_q;
  logic        bd_go_q;
  logic [3:0]  tx_st;
  logic [4:0]  tx_space;
  logic [7:0]  tx_len;
  logic        fetch_req;
  logic [2:0]  ph;
  logic [7:0]  mout;
  logic        mval;
  logic        csn;
  logic [1:0]  dev;
  logic [31:0] rd_d;

  assign cfg.flash_target_select = dsel_q;
  assign cfg.mode_cycle_count    = mcnt_q;
  assign cfg.mode_code_value     = mcode_q;

  // XIP control and poll registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dsel_q <= qsx_pkg::DSEL_RST;
      mcnt_q <= qsx_pkg::MCNT_RST;
      mcode_q <= qsx_pkg::MCODE_RST;
      poll_q <= qsx_pkg::POLL_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == qsx_pkg::XIP_CTRL2_IDX)
      begin
        // Reserved targets are ignored so a bad write never selects none
        if (reg_wdata[qsx_pkg::TGT_SEL_LSB +: 2] == qsx_pkg::DSEL_DEV0 ||
            reg_wdata[qsx_pkg::TGT_SEL_LSB +: 2] == qsx_pkg::DSEL_DEV1)
          dsel_q <= reg_wdata[qsx_pkg::TGT_SEL_LSB +: 2];
        mcnt_q <= reg_wdata[qsx_pkg::MCOUNT_LSB +: 2];
        mcode_q <= reg_wdata[7:0];
      end
      if (reg_addr == qsx_pkg::BD_POLL_IDX)
        poll_q <= reg_wdata[15:0];
    end
  end

  // Command register: cycle counts and start pulses
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      addr_cyc_q <= qsx_pkg::ADDR_CYC_RST;
      dummy_cyc_q <= qsx_pkg::DUMMY_CYC_RST;
      data_cyc_q <= qsx_pkg::DATA_CYC_RST;
      xip_start_q <= 1'b0;
      bd_go_q <= 1'b0;
    end
    else
    begin
      xip_start_q <= 1'b0;
      bd_go_q <= 1'b0;
      if (reg_wr && reg_addr == qsx_pkg::XIP_CMD_IDX)
      begin
        addr_cyc_q <= reg_wdata[2:0];
        dummy_cyc_q <= reg_wdata[6:4];
        data_cyc_q <= reg_wdata[11:8];
        xip_start_q <= reg_wdata[31];
      end
      if (reg_wr && reg_addr == qsx_pkg::BD_CMD_IDX)
        bd_go_q <= reg_wdata[0];
    end
  end

  qsx_xip_seq u_seq (
    .mclk         (mclk),
    .rst          (rst),
    .cfg          (cfg.seq),
    .xip_start    (xip_start_q),
    .addr_cycles  (addr_cyc_q),
    .dummy_cycles (dummy_cyc_q),
    .data_cycles  (data_cyc_q),
    .phase_q      (ph),
    .mode_out_q   (mout),
    .mode_valid_q (mval),
    .cs_n_q       (csn),
    .dev_q        (dev)
  );

  qsx_bd_tx_fsm u_bd (
    .mclk                       (mclk),
    .rst                        (rst),
    .bd_go                      (bd_go_q),
    .descriptor_poll_wait       (poll_q),
    .fetch_done                 (fetch_done),
    .fetch_enabled              (fetch_enabled),
    .fetch_len                  (fetch_len),
    .byte_out                   (byte_out),
    .fetch_req_q                (fetch_req),
    .tx_dma_state_q             (tx_st),
    .tx_fifo_space_q            (tx_space),
    .tx_current_buffer_length_q (tx_len)
  );

  // Read mux; unimplemented bits and unmapped indices read zero
  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (reg_addr)
      qsx_pkg::XIP_CTRL2_IDX:
        rd_d = {20'h00000, dsel_q, mcnt_q, mcode_q};
      qsx_pkg::BD_POLL_IDX:
        rd_d = {16'h0000, poll_q};
      qsx_pkg::TX_STAT_IDX:
        rd_d = {3'h0, tx_st, 4'h0, tx_space, 8'h00, tx_len};
      qsx_pkg::XIP_CMD_IDX:
        rd_d = {20'h00000, data_cyc_q, 1'b0, dummy_cyc_q, 1'b0,
                addr_cyc_q};
      qsx_pkg::BD_STAT_IDX:
        rd_d = {27'h0000000, ph, csn, mval};
      default:
        rd_d = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (rst)
      reg_rdata_q <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata_q <= rd_d;
    else
      reg_rdata_q <= 32'h0000_0000;
  end

  // Outputs straight from flip-flops
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fetch_req_q <= 1'b0;
      xip_phase_q <= 3'h0;
      mode_out_q <= 8'h00;
      mode_valid_q <= 1'b0;
      flash_cs_n_q <= 1'b1;
      flash_dev_q <= 2'h0;
    end
    else
    begin
      fetch_req_q <= fetch_req;
      xip_phase_q <= ph;
      mode_out_q <= mout;
      mode_valid_q <= mval;
      flash_cs_n_q <= csn;
      flash_dev_q <= dev;
    end
  end
endmodule

/* File: tb/qsx_regs_props.sv */
// Checker for qsx_regs: read-back masks and XIP phase relations.
// Assumes the bind below, one clock mclk and sync active-high rst.
`timescale 1ns/1ns
module qsx_regs_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_q,
  input wire logic        fetch_req_q,
  input wire logic [2:0]  xip_phase_q,
  input wire logic [7:0]  mode_out_q,
  input wire logic        mode_valid_q,
  input wire logic        flash_cs_n_q,
  input wire logic [1:0]  flash_dev_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [7:0] code_q;
  // Shadow of the stored mode code; writes never land mid-access
  always_ff @(posedge mclk)
    if (rst)
      code_q <= 8'h00;
    else if (reg_wr && reg_addr == qsx_pkg::XIP_CTRL2_IDX)
      code_q <= reg_wdata[7:0];
  xip_hi_zero_a: assert property (reg_rd && reg_addr == 4'h0 |=>
    reg_rdata_q[31:12] == 20'h00000) else $error("xip upper bits set");
  poll_hi_zero_a: assert property (reg_rd && reg_addr == 4'h1 |=>
    reg_rdata_q[31:16] == 16'h0000) else $error("poll upper bits set");
  stat_rsvd_zero_a: assert property (reg_rd && reg_addr == 4'h2 |=>
    {reg_rdata_q[31:29], reg_rdata_q[24:21], reg_rdata_q[15:8]} == 15'h0)
    else $error("status reserved bits set");
  stat_space_max_a: assert property (reg_rd && reg_addr == 4'h2 |=>
    reg_rdata_q[20:16] <= 5'h10) else $error("fifo space above depth");
  mode_phase_tie_a: assert property (mode_valid_q ==
    (xip_phase_q == 3'h2)) else $error("mode flag off its phase");
  mode_code_out_a: assert property (mode_valid_q |->
    mode_out_q == code_q) else $error("mode bits differ from code");
  mode_len_max_a: assert property (mode_valid_q [*3] |=>
    !mode_valid_q) else $error("more than three mode cycles");
  mode_after_addr_a: assert property ($rose(mode_valid_q) |->
    $past(xip_phase_q) == 3'h1) else $error("mode not after address");
  dev_legal_a: assert property (!flash_cs_n_q |->
    !flash_dev_q[1]) else $error("reserved device selected");
  cover property ($rose(mode_valid_q));
  cover property (fetch_req_q);
  cover property (!flash_cs_n_q && flash_dev_q == 2'h1);
endmodule
bind qsx_regs qsx_regs_props u_props (.mclk(mclk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .fetch_req_q(fetch_req_q),
  .xip_phase_q(xip_phase_q), .mode_out_q(mode_out_q),
  .mode_valid_q(mode_valid_q), .flash_cs_n_q(flash_cs_n_q),
  .flash_dev_q(flash_dev_q));

/* File: tb/qsx_desc_model.sv */
// Far-side model: answers descriptor fetches and sends transmit bytes.
// Assumes the bench sets latency (at least 1), enable, length and count.
`timescale 1ns/1ns
module qsx_desc_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       fetch_req_q,
  input  wire logic [2:0] lat,
  input  wire logic       desc_en,
  input  wire logic [7:0] desc_len,
  input  wire logic [7:0] n_bytes,
  output logic            fetch_done,
  output logic            fetch_enabled,
  output logic [7:0]      fetch_len,
  output logic            byte_out
);
  logic [2:0] lat_q;
  logic [7:0] left_q;
  logic [7:0] cnt_q;
  // Answer after lat cycles, then one byte every other cycle
  always_ff @(posedge mclk)
    if (rst)
    begin
      fetch_done <= 1'b0;
      byte_out <= 1'b0;
      lat_q <= 3'h0;
      left_q <= 8'h00;
      cnt_q <= 8'h00;
    end
    else
    begin
      cnt_q <= cnt_q + 8'h01;
      fetch_done <= (lat_q == 3'h1);
      byte_out <= 1'b0;
      if (fetch_req_q)
        lat_q <= lat;
      else if (lat_q != 3'h0)
        lat_q <= lat_q - 3'h1;
      if (lat_q == 3'h1 && desc_en)
        left_q <= n_bytes;
      else if (left_q != 8'h00 && !byte_out)
      begin
        byte_out <= 1'b1;
        left_q <= left_q - 8'h01;
      end
    end
  // Answer fields are only meaningful with the pulse; churn otherwise
  assign fetch_enabled = fetch_done ? desc_en : cnt_q[0];
  assign fetch_len = fetch_done ? desc_len : cnt_q;
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for qsx_regs with the descriptor far-side model.
// Assumes 25 MHz mclk and the strobe register bus of the design.
`timescale 1ns/1ns
module testbench;
  logic        mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata_q, d, w;
  logic        fetch_done, fetch_enabled, byte_out, fetch_req_q;
  logic        mode_valid_q, flash_cs_n_q, desc_en = 0;
  logic [7:0]  fetch_len, mode_out_q, mlast, desc_len = 0, n_bytes = 0;
  logic [2:0]  xip_phase_q, lat = 1;
  logic [1:0]  flash_dev_q, dseen;
  int mismatches = 0, n_tests = 0, seed = 9, cyc = 0, t_done = 0;
  int t_req = 0, nmode = 0, n0 = 0, i, k;
  always #20 mclk = ~mclk;
  // Event log sampled at each rising edge, read by the main sequence
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (fetch_done) t_done <= cyc;
    if (fetch_req_q) t_req <= cyc;
    if (mode_valid_q) nmode <= nmode + 1;
    if (mode_valid_q) mlast <= mode_out_q;
    if (!flash_cs_n_q) dseen <= flash_dev_q;
  end
  qsx_regs u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .fetch_done(fetch_done), .fetch_enabled(fetch_enabled),
    .fetch_len(fetch_len), .byte_out(byte_out), .reg_rdata_q(reg_rdata_q),
    .fetch_req_q(fetch_req_q), .xip_phase_q(xip_phase_q),
    .mode_out_q(mode_out_q), .mode_valid_q(mode_valid_q),
    .flash_cs_n_q(flash_cs_n_q), .flash_dev_q(flash_dev_q));
  qsx_desc_model u_far (.mclk(mclk), .rst(rst), .fetch_req_q(fetch_req_q),
    .lat(lat), .desc_en(desc_en), .desc_len(desc_len), .n_bytes(n_bytes),
    .fetch_done(fetch_done), .fetch_enabled(fetch_enabled),
    .fetch_len(fetch_len), .byte_out(byte_out));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // XIP control read-back: only the low twelve bits exist
  function automatic logic [31:0] xip_exp(input logic [31:0] v);
    return v & 32'h0000_0FFF;
  endfunction
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1;
    @(posedge mclk);
    reg_wr <= 0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge mclk);
    reg_rd <= 0;
    #1 v = reg_rdata_q;
  endtask
  task end_sim;
    $display("mismatches %0d of %0d checks", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    end_sim;
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 0;
    rd(4'h0, d); chk("xip ctrl", d, 32'h0);
    rd(4'h1, d); chk("poll", d, 32'h0);
    wr(4'h2, 32'hFFFF_FFFF);
    rd(4'h2, d); chk("tx status", d, 32'h0010_0000);
    rd(4'hF, d); chk("unmapped", d, 32'h0);
    for (i = 0; i < 8; i++)
    begin
      w = $random(seed) & 32'hFFFF_F7FF;
      wr(4'h0, w);
      rd(4'h0, d); chk("xip ctrl", d, xip_exp(w));
    end
    // Reserved target code must leave device 1 in place
    wr(4'h0, 32'h0000_0400);
    wr(4'h0, 32'h0000_0B5A);
    rd(4'h0, d); chk("target keep", d, 32'h0000_075A);
    for (i = 0; i < 4; i++)
    begin
      w = $random(seed);
      wr(4'h1, w);
      rd(4'h1, d); chk("poll", d, w & 32'hFFFF);
    end
    for (i = 0; i < 4; i++)
    begin
      w = {20'h0, 2'(i % 2), 2'(i), 8'($random(seed))};
      wr(4'h0, w);
      n0 = nmode;
      wr(4'h3, 32'h8000_0213);
      for (k = 0; k < 20 && flash_cs_n_q; k++) @(posedge mclk);
      for (k = 0; k < 60 && !flash_cs_n_q; k++) @(posedge mclk);
      repeat (3) @(posedge mclk);
      chk("mode cycles", nmode - n0, i);
      if (i > 0) chk("mode bits", mlast, w[7:0]);
      chk("device", dseen, w[11:10]);
    end
    // Command word read-back and idle sequencer status
    rd(4'h3, d); chk("xip cmd", d, 32'h0000_0213);
    rd(4'h5, d); chk("seq status", d, 32'h0000_0002);
    wr(4'h1, 32'h0000_0028);
    wr(4'h4, 32'h1);
    for (k = 0; k < 50 && t_done == 0; k++) @(posedge mclk);
    repeat (5) @(posedge mclk);
    rd(4'h2, d); chk("tx state", d[28:25], 4'h2);
    desc_en = 1;
    desc_len = 8'($random(seed)) | 8'h10;
    n_bytes = 5;
    lat = 3'h4;
    for (k = 0; k < 100 && t_req <= t_done; k++) @(posedge mclk);
    k = t_req - t_done;
    chk("poll wait", (k >= 41) && (k <= 44), 1);
    repeat (30) @(posedge mclk);
    rd(4'h2, d);
    chk("tx status", d, {7'h03, 9'h00B, 8'h0, desc_len});
    end_sim;
  end
endmodule
